// ### rtl/zlf_pkg.sv
// Purpose: shared constants and carriers for the loop flow control block
// Assumes: 32-bit instruction addresses, one core clock
// Notes:   loop control word is three 4-bit fields, enable in the top bit
package zlf_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int NUM_LOOPS   = 3;
  localparam int ADDR_W      = 32;
  localparam int FIELD_W     = 4;
  localparam int SEL_W       = 3;
  localparam int CTL_W       = NUM_LOOPS * FIELD_W;
  localparam int DELAY_SLOTS = 2;

  // ****************************************************************
  // loop control word layout and values
  // ****************************************************************
  localparam int FIELD_EN_BIT = 3;
  localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] PC_STEP  = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;

  // counter select codes; 1xx is reserved and never branches
  typedef enum logic [2:0] {
    ZLF_SEL_NONE = 3'b000,
    ZLF_SEL_C0   = 3'b001,
    ZLF_SEL_C1   = 3'b010,
    ZLF_SEL_C2   = 3'b011
  } zlf_sel_e;

  // software load size and addressing form
  typedef enum logic [1:0] {
    ZLF_SZ_BYTE = 2'b00,
    ZLF_SZ_HALF = 2'b01,
    ZLF_SZ_WORD = 2'b10
  } zlf_size_e;

  // loop register selectors for execute-stage writes
  typedef enum logic [2:0] {
    ZLF_REG_END    = 3'b000,
    ZLF_REG_START  = 3'b001,
    ZLF_REG_COUNT  = 3'b010,
    ZLF_REG_RELOAD = 3'b011,
    ZLF_REG_CTL    = 3'b100
  } zlf_reg_e;

  localparam logic [3:0] ALU_CLASS_PC = 4'h7;

  // execute-stage write of the program counter
  typedef struct packed {
    logic              valid;
    logic              from_alu;   // else from a load
    logic [3:0]        alu_class;
    logic              src2_ok;    // second source is data reg or imm
    logic              routed;     // passes rotator/mask/expander
    zlf_size_e         size;
    logic              unscaled;   // unscaled immediate offset form
    logic [ADDR_W-1:0] target;
  } zlf_pcwr_s;

  // execute-stage write of a loop register
  typedef struct packed {
    logic              valid;
    zlf_reg_e          which;
    logic [1:0]        index;
    logic [ADDR_W-1:0] data;
  } zlf_lwr_s;

endpackage : zlf_pkg

// ### rtl/zlf_delay.sv
// Purpose: fixed-length shift of a pc write through the delay slots
// Assumes: one entry per cycle from the execute stage
// Notes:   depth sets the number of delay-slot fetches
`timescale 1ns/1ns
module zlf_delay #(
  parameter int DEPTH = zlf_pkg::DELAY_SLOTS
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // data
  input  wire logic              in_valid,
  input  wire logic [zlf_pkg::ADDR_W-1:0] in_addr,
  output logic                   out_valid,
  output logic [zlf_pkg::ADDR_W-1:0] out_addr
);
  logic [DEPTH-1:0]              vld_q;
  logic [zlf_pkg::ADDR_W-1:0]    adr_q [DEPTH];

  // shift stages; first stage takes the execute-stage write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vld_q <= '0;
    end else begin
      vld_q <= {vld_q[DEPTH-2:0], in_valid};
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      // split at elaboration so stage zero never names a stage below it
      if (g == 0) begin : g_first
        always_ff @(posedge core_clk) begin
          adr_q[g] <= in_addr;
        end
      end else begin : g_next
        always_ff @(posedge core_clk) begin
          adr_q[g] <= adr_q[g-1];
        end
      end
    end
  endgenerate

  assign out_valid = vld_q[DEPTH-1];
  assign out_addr  = adr_q[DEPTH-1];
endmodule : zlf_delay

// ### rtl/zlf_match.sv
// Purpose: one loop end comparator with its counter-select decode
// Assumes: field and counters already registered
// Notes:   combinational; priority is resolved by the parent
`timescale 1ns/1ns
module zlf_match #(
  parameter int IDX = 0
) (
  // inputs
  input  wire logic [zlf_pkg::ADDR_W-1:0] pc,
  input  wire logic [zlf_pkg::ADDR_W-1:0] loop_end,
  input  wire logic [zlf_pkg::FIELD_W-1:0] field,
  input  wire logic [zlf_pkg::NUM_LOOPS-1:0] cnt_zero,
  // outputs
  output logic                   hit,
  output logic                   uses_cnt,
  output logic [1:0]             cnt_idx,
  output logic                   take
);
  logic [zlf_pkg::SEL_W-1:0] sel;
  always_comb begin
    sel      = field[zlf_pkg::SEL_W-1:0];
    hit      = field[zlf_pkg::FIELD_EN_BIT] && (pc == loop_end);
    uses_cnt = 1'b0;
    cnt_idx  = 2'd0;
    take     = 1'b0;
    // only none, counter zero, or own counter are legal
    case (sel)
      zlf_pkg::ZLF_SEL_NONE: take = 1'b1;
      zlf_pkg::ZLF_SEL_C0: begin
        uses_cnt = 1'b1;
        cnt_idx  = 2'd0;
        take     = !cnt_zero[0];
      end
      zlf_pkg::ZLF_SEL_C1: begin
        uses_cnt = (IDX == 1);
        cnt_idx  = 2'd1;
        take     = (IDX == 1) && !cnt_zero[1];
      end
      zlf_pkg::ZLF_SEL_C2: begin
        uses_cnt = (IDX == 2);
        cnt_idx  = 2'd2;
        take     = (IDX == 2) && !cnt_zero[2];
      end
      default: take = 1'b0;  // reserved codes never loop
    endcase
  end
endmodule : zlf_match

// ### rtl/zlf_flow.sv
// Purpose: program counter with zero-overhead loops and software branches
// Assumes: fetch uses pc each cycle; execute writes arrive as structs
// Notes:   loop registers are written from execute; hardware acts in fetch
`timescale 1ns/1ns

// What this block does
// - pc loads must be word size; byte or halfword loads are refused.
// - unscaled-offset pc load is the interrupt-return form, flagged.
// - class 7 two-input alu ops may write pc, unrouted inputs only.
// - first source any register, second a data register or immediate.
// - long branches need a 32-bit immediate; short ones fit small.
// - software branch lands after exactly two delay-slot fetches.
// - three independent loop controllers with their own registers.
// - loop back happens in fetch, target fetched next cycle.
// - each fetch compares pc with every enabled loop end.
// - match with nonzero counter branches and decrements together.
// - match with zero counter falls through and reloads counter.
// - reload write also writes counter; counter write keeps reload.
// - control word holds three 4-bit fields, enable plus select.
// - a loop end uses none, counter zero, or its own counter.
// - pc-writing alu ops leave status flags untouched.
// - select 000 none, 001 c0, 010 c1, 011 c2, 1xx reserved.
// - reset clears all three loop enables.
module zlf_flow #(
  parameter int NL = zlf_pkg::NUM_LOOPS
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // fetch stage
  output logic [zlf_pkg::ADDR_W-1:0]  fetch_pc,
  output logic                        loop_taken,
  // execute stage writes
  input  wire zlf_pkg::zlf_pcwr_s     pc_write,
  input  wire zlf_pkg::zlf_lwr_s      loop_write,
  // status
  output logic                        pc_write_illegal,
  output logic                        reti_form,
  output logic                        status_hold,
  output logic [zlf_pkg::CTL_W-1:0]   loop_ctl
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [zlf_pkg::ADDR_W-1:0] pc_q;
  logic [zlf_pkg::ADDR_W-1:0] end_q    [NL];
  logic [zlf_pkg::ADDR_W-1:0] start_q  [NL];
  logic [zlf_pkg::ADDR_W-1:0] count_q  [NL];
  logic [zlf_pkg::ADDR_W-1:0] reload_q [NL];
  logic [zlf_pkg::CTL_W-1:0]  ctl_q;
  logic                       taken_q;
  logic                       illegal_q;
  logic                       reti_q;
  logic                       hold_q;

  logic [NL-1:0]              hit;
  logic [NL-1:0]              uses;
  logic [NL-1:0]              take;
  logic [NL-1:0]              cz;
  logic [1:0]                 cidx     [NL];
  logic                       any_hit;
  logic [1:0]                 win;
  logic                       accept;
  logic                       sw_valid;
  logic [zlf_pkg::ADDR_W-1:0] sw_addr;

  // ****************************************************************
  // comparators
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_loop
      assign cz[g] = (count_q[g] == '0);
      zlf_match #(.IDX(g)) u_match (
        .pc       (pc_q),
        .loop_end (end_q[g]),
        .field    (ctl_q[g*zlf_pkg::FIELD_W +: zlf_pkg::FIELD_W]),
        .cnt_zero (cz),
        .hit      (hit[g]),
        .uses_cnt (uses[g]),
        .cnt_idx  (cidx[g]),
        .take     (take[g])
      );
    end
  endgenerate

  // fixed priority, loop end zero first
  always_comb begin
    any_hit = |hit;
    win     = 2'd0;
    for (int i = NL - 1; i >= 0; i--) begin
      if (hit[i]) win = 2'(i);
    end
  end

  // ****************************************************************
  // software pc write check and delay slots
  // ****************************************************************
  // an illegal write is dropped rather than corrupting the pc
  always_comb begin
    if (pc_write.from_alu) begin
      accept = (pc_write.alu_class == zlf_pkg::ALU_CLASS_PC)
               && !pc_write.routed
               && pc_write.src2_ok;
    end else begin
      accept = (pc_write.size == zlf_pkg::ZLF_SZ_WORD);
    end
  end

  zlf_delay #(.DEPTH(zlf_pkg::DELAY_SLOTS)) u_delay (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (pc_write.valid && accept),
    .in_addr   (pc_write.target),
    .out_valid (sw_valid),
    .out_addr  (sw_addr)
  );

  // status flags for the execute stage, registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      illegal_q <= 1'b0;
      reti_q    <= 1'b0;
      hold_q    <= 1'b0;
    end else begin
      illegal_q <= pc_write.valid && !accept;
      reti_q    <= pc_write.valid && accept && !pc_write.from_alu
                   && pc_write.unscaled;
      hold_q    <= pc_write.valid && pc_write.from_alu;
    end
  end

  // ****************************************************************
  // program counter
  // ****************************************************************
  // loop back wins over the delayed software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_q    <= zlf_pkg::PC_RESET;
      taken_q <= 1'b0;
    end else if (any_hit && take[win]) begin
      pc_q    <= start_q[win];
      taken_q <= 1'b1;
    end else if (sw_valid) begin
      pc_q    <= sw_addr;
      taken_q <= 1'b0;
    end else begin
      pc_q    <= pc_q + zlf_pkg::PC_STEP;
      taken_q <= 1'b0;
    end
  end

  // ****************************************************************
  // loop registers
  // ****************************************************************
  generate
    for (g = 0; g < NL; g++) begin : g_regs
      always_ff @(posedge core_clk) begin
        if (loop_write.valid && loop_write.index == 2'(g)) begin
          if (loop_write.which == zlf_pkg::ZLF_REG_END)
            end_q[g] <= loop_write.data;
          if (loop_write.which == zlf_pkg::ZLF_REG_START)
            start_q[g] <= loop_write.data;
          if (loop_write.which == zlf_pkg::ZLF_REG_RELOAD)
            reload_q[g] <= loop_write.data;
        end
      end

      // hardware update beats a software write in the same cycle
      always_ff @(posedge core_clk) begin
        if (any_hit && uses[win] && cidx[win] == 2'(g)) begin
          if (cz[g])
            count_q[g] <= reload_q[g];
          else
            count_q[g] <= count_q[g] - zlf_pkg::PC_STEP;
        end else if (loop_write.valid && loop_write.index == 2'(g)
                     && (loop_write.which == zlf_pkg::ZLF_REG_COUNT
                     || loop_write.which == zlf_pkg::ZLF_REG_RELOAD)) begin
          count_q[g] <= loop_write.data;
        end
      end
    end
  endgenerate

  // control word; enables cleared at reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl_q <= zlf_pkg::CTL_RESET;
    end else if (loop_write.valid
                 && loop_write.which == zlf_pkg::ZLF_REG_CTL) begin
      ctl_q <= loop_write.data[zlf_pkg::CTL_W-1:0];
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign fetch_pc         = pc_q;
  assign loop_taken       = taken_q;
  assign pc_write_illegal = illegal_q;
  assign reti_form        = reti_q;
  assign status_hold      = hold_q;
  assign loop_ctl         = ctl_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_hit_take;
    any_hit && take[win];
  endsequence

  property p_loop_back;
    @(posedge core_clk) disable iff (reset)
    s_hit_take |=> (fetch_pc == $past(start_q[win])) && loop_taken;
  endproperty
  loop_back_pc_a: assert property (p_loop_back)
    else $error("loop back did not load start");

  fall_through_a: assert property (@(posedge core_clk) disable iff (reset)
    (any_hit && !take[win] && !sw_valid) |=>
      fetch_pc == $past(pc_q) + zlf_pkg::PC_STEP)
    else $error("zero count did not fall through");

  sw_branch_a: assert property (@(posedge core_clk) disable iff (reset)
    (pc_write.valid && accept && !pc_write.from_alu) ##2 !any_hit
      |=> fetch_pc == $past(pc_write.target, 3))
    else $error("software branch not after two slots");

  bad_size_a: assert property (@(posedge core_clk) disable iff (reset)
    (pc_write.valid && !pc_write.from_alu
     && pc_write.size != zlf_pkg::ZLF_SZ_WORD) |=> pc_write_illegal)
    else $error("narrow pc load accepted");

  ctl_reset_a: assert property (@(posedge core_clk)
    reset |=> loop_ctl == zlf_pkg::CTL_RESET)
    else $error("enables not cleared");

  count_dec_a: assert property (@(posedge core_clk) disable iff (reset)
    (any_hit && uses[win] && !cz[cidx[win]]) |=>
      count_q[$past(cidx[win])] == $past(count_q[cidx[win]]) - 1)
    else $error("counter not decremented");

  prio_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    hit[0] |-> win == 2'd0)
    else $error("loop end zero lost priority");

  reload_copy_a: assert property (@(posedge core_clk) disable iff (reset)
    (loop_write.valid && loop_write.which == zlf_pkg::ZLF_REG_RELOAD
     && !any_hit) |=> count_q[$past(loop_write.index)]
      == $past(loop_write.data))
    else $error("reload write missed counter");

  reti_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    (pc_write.valid && !pc_write.from_alu && pc_write.unscaled
     && pc_write.size == zlf_pkg::ZLF_SZ_WORD) |=> reti_form)
    else $error("return form not flagged");

  // ****************************************************************
  // counter select and status checks
  // ****************************************************************
  // a winning end on a zero counter must reload, never wrap to all ones
  sequence s_hit_zero;
    any_hit && uses[win] && cz[cidx[win]];
  endsequence

  // select none branches with no counter in the way
  sequence s_hit_none;
    any_hit && ctl_q[win*zlf_pkg::FIELD_W +: zlf_pkg::SEL_W]
      == zlf_pkg::ZLF_SEL_NONE;
  endsequence

  // reserved selects have the top select bit set
  sequence s_hit_resv;
    any_hit && ctl_q[win*zlf_pkg::FIELD_W + zlf_pkg::SEL_W - 1];
  endsequence

  count_reload_a: assert property (@(posedge core_clk) disable iff (reset)
    s_hit_zero |=> count_q[$past(cidx[win])] == $past(reload_q[cidx[win]]))
    else $error("zero counter not reloaded");

  no_count_a: assert property (@(posedge core_clk) disable iff (reset)
    s_hit_none |=> loop_taken && fetch_pc == $past(start_q[win]))
    else $error("counterless end did not branch");

  reserved_sel_a: assert property (@(posedge core_clk) disable iff (reset)
    s_hit_resv |=> !loop_taken)
    else $error("reserved select branched");

  // the execute stage relies on this pulse to keep its flags
  alu_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (pc_write.valid && pc_write.from_alu) |=> status_hold)
    else $error("alu pc write did not hold status");

  alu_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
    (pc_write.valid && pc_write.from_alu
     && (pc_write.alu_class != zlf_pkg::ALU_CLASS_PC
         || pc_write.routed || !pc_write.src2_ok)) |=> pc_write_illegal)
    else $error("bad alu pc write accepted");

  // a taken flag without a loop back would mislead the fetch stage
  taken_cause_a: assert property (@(posedge core_clk) disable iff (reset)
    loop_taken |-> $past(any_hit && take[win]))
    else $error("loop taken without a loop back");
endmodule : zlf_flow

// ### verification/zlf_exec_model.sv
// Purpose: execute-stage stand-in that issues pc and loop writes
// Assumes: each request starts on a rising edge
// Notes:   a request stands for one taking edge, then valid drops
`timescale 1ns/1ns
module zlf_exec_model (
  // clock
  input  wire logic          core_clk,
  // execute-stage writes
  output zlf_pkg::zlf_pcwr_s pc_write,
  output zlf_pkg::zlf_lwr_s  loop_write
);
  // idle bus at time zero
  initial begin
    pc_write   = '0;
    loop_write = '0;
  end

  // the gap edge keeps two requests out of one time step
  task automatic send_pc(input zlf_pkg::zlf_pcwr_s req);
    @(posedge core_clk);
    pc_write <= req;
    @(posedge core_clk);
    pc_write.valid <= 1'b0;
  endtask : send_pc

  // loop register write, full 32-bit word
  task automatic send_loop(input zlf_pkg::zlf_lwr_s req);
    @(posedge core_clk);
    loop_write <= req;
    @(posedge core_clk);
    loop_write.valid <= 1'b0;
  endtask : send_loop
endmodule : zlf_exec_model

// ### verification/testbench.sv
// Purpose: self-checking bench for the loop flow control block
// Assumes: fetch_pc steps by one per cycle outside branches
// Notes:   a shadow model predicts fetch_pc and loop_taken each cycle
`timescale 1ns/1ns
module testbench;
  // ****************************************************************
  // signals, shadow model state
  // ****************************************************************
  typedef struct packed {
    zlf_pkg::zlf_pcwr_s req;
    logic [2:0]         flags; // illegal, reti, hold
  } zlf_row_s;
  logic               core_clk;
  logic               reset;
  logic [31:0]        fetch_pc;
  logic               loop_taken;
  logic               pc_write_illegal;
  logic               reti_form;
  logic               status_hold;
  logic [11:0]        loop_ctl;
  zlf_pkg::zlf_pcwr_s pc_write;
  zlf_pkg::zlf_lwr_s  loop_write;
  int                 mismatches;
  int                 tests_run;
  int                 land_c;
  bit                 track;
  logic [31:0]        exp_pc, land_t, base, le[3], ls[3], lc[3], lr[3];
  logic [11:0]        exp_ctl;
  logic               exp_tk;
  zlf_row_s           rows[8];

  // 20 MHz core clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  zlf_flow zlf_flow_inst (.core_clk(core_clk), .reset(reset),
    .fetch_pc(fetch_pc), .loop_taken(loop_taken), .pc_write(pc_write),
    .loop_write(loop_write), .pc_write_illegal(pc_write_illegal),
    .reti_form(reti_form), .status_hold(status_hold),
    .loop_ctl(loop_ctl));
  zlf_exec_model zlf_exec_model_inst (.core_clk(core_clk),
    .pc_write(pc_write), .loop_write(loop_write));

  // compare and count; four-state so x matches only x
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  function automatic zlf_row_s mk(logic a, logic [3:0] c, logic ok,
      logic rt, zlf_pkg::zlf_size_e sz, logic us, logic [2:0] fl);
    mk = '{'{1'b1, a, c, ok, rt, sz, us, 32'h0000_0000}, fl};
  endfunction : mk

  // next fetch address; lowest matching enabled end wins
  task automatic step();
    logic [31:0] nx;
    logic [2:0]  sel;
    int          c;
    bit          hit;
    nx = exp_pc + 32'h0000_0001;
    hit = 0;
    exp_tk = 1'b0;
    for (int i = 0; i < 3; i++) begin
      sel = exp_ctl[4*i +: 3];
      c = (sel == 3'h1) ? 0 : (sel == 3'h2 && i == 1) ? 1 :
          (sel == 3'h3 && i == 2) ? 2 : 3;
      if (!hit && exp_ctl[4*i+3] && le[i] === exp_pc) begin
        hit = 1;
        if (sel == 3'h0 || (c < 3 && lc[c] != 0)) begin
          nx = ls[i];
          exp_tk = 1'b1;
          if (sel != 3'h0) lc[c] = lc[c] - 32'h0000_0001;
        end else if (c < 3) lc[c] = lr[c];
      end
    end
    // software target lands two fetches after its taking edge
    if (land_c != 0) begin
      land_c--;
      if (land_c == 0 && !hit) nx = land_t;
    end
    exp_pc = nx;
  endtask : step

  // loop register write, mirrored into the shadow model
  task automatic wr(zlf_pkg::zlf_reg_e w, logic [1:0] i, logic [31:0] d);
    zlf_exec_model_inst.send_loop(zlf_pkg::zlf_lwr_s'{1'b1, w, i, d});
    case (w)
      zlf_pkg::ZLF_REG_END: le[i] = d;
      zlf_pkg::ZLF_REG_START: ls[i] = d;
      zlf_pkg::ZLF_REG_COUNT: lc[i] = d;
      zlf_pkg::ZLF_REG_RELOAD: begin
        lr[i] = d;
        lc[i] = d;
      end
      default: exp_ctl = d[11:0];
    endcase
  endtask : wr

  task automatic restart();
    exp_pc = 32'h0000_0000;
    exp_ctl = 12'h000;
    exp_tk = 1'b0;
    land_c = 0;
    track = 1;
  endtask : restart

  // per-cycle compare, after the edge has settled
  always @(posedge core_clk) begin
    #1;
    if (track) begin
      check("fetch_pc", fetch_pc, exp_pc);
      check("loop_taken", {31'h0, loop_taken}, {31'h0, exp_tk});
      check("loop_ctl", {20'h0, loop_ctl}, {20'h0, exp_ctl});
      step();
    end
  end

  // watchdog: the whole run needs well under 400 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    track = 0;
    mismatches = 0;
    tests_run = 0;
    rows = '{mk(1, 4'h7, 1, 0, zlf_pkg::ZLF_SZ_WORD, 0, 3'b001),
             mk(1, 4'h6, 1, 0, zlf_pkg::ZLF_SZ_WORD, 0, 3'b100),
             mk(1, 4'h7, 1, 1, zlf_pkg::ZLF_SZ_WORD, 0, 3'b100),
             mk(1, 4'h7, 0, 0, zlf_pkg::ZLF_SZ_WORD, 0, 3'b100),
             mk(0, 4'h0, 1, 0, zlf_pkg::ZLF_SZ_WORD, 0, 3'b000),
             mk(0, 4'h0, 1, 0, zlf_pkg::ZLF_SZ_HALF, 0, 3'b100),
             mk(0, 4'h0, 1, 0, zlf_pkg::ZLF_SZ_BYTE, 0, 3'b100),
             mk(0, 4'h0, 1, 0, zlf_pkg::ZLF_SZ_WORD, 1, 3'b010)};
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    restart();
    // software pc writes: accepted, refused and return form
    for (int i = 0; i < 8; i++) begin
      rows[i].req.target = 32'h0000_0100 + 32'(i) * 32'h0000_0010;
      zlf_exec_model_inst.send_pc(rows[i].req);
      if (!rows[i].flags[2]) begin
        land_t = rows[i].req.target;
        land_c = 2;
      end
      #1;
      check("illegal", {31'h0, pc_write_illegal}, {31'h0, rows[i].flags[2]});
      check("reti", {31'h0, reti_form}, {31'h0, rows[i].flags[1]});
      if (!rows[i].flags[2]) check("hold", {31'h0, status_hold}, {31'h0, rows[i].flags[0]});
    end
    // nested loops: inner starts with count 0, end 0 shadows end 2
    base = exp_pc + 32'h0000_0028;
    wr(zlf_pkg::ZLF_REG_END, 2'h0, base + 32'h0000_0004);
    wr(zlf_pkg::ZLF_REG_START, 2'h0, base + 32'h0000_0002);
    wr(zlf_pkg::ZLF_REG_RELOAD, 2'h0, 32'h0000_0002);
    wr(zlf_pkg::ZLF_REG_COUNT, 2'h0, 32'h0000_0000);
    wr(zlf_pkg::ZLF_REG_END, 2'h1, base + 32'h0000_0007);
    wr(zlf_pkg::ZLF_REG_START, 2'h1, base);
    wr(zlf_pkg::ZLF_REG_RELOAD, 2'h1, 32'h0000_0001);
    wr(zlf_pkg::ZLF_REG_END, 2'h2, base + 32'h0000_0004);
    wr(zlf_pkg::ZLF_REG_START, 2'h2, base + 32'h0000_0001);
    wr(zlf_pkg::ZLF_REG_CTL, 2'h0, 32'h0000_09a9);
    repeat (60) @(posedge core_clk);
    // counterless branch plus reserved and foreign selects
    base = exp_pc + 32'h0000_0014;
    wr(zlf_pkg::ZLF_REG_END, 2'h0, base + 32'h0000_0003);
    wr(zlf_pkg::ZLF_REG_START, 2'h0, base);
    wr(zlf_pkg::ZLF_REG_END, 2'h1, base + 32'h0000_0001);
    wr(zlf_pkg::ZLF_REG_END, 2'h2, base + 32'h0000_0002);
    wr(zlf_pkg::ZLF_REG_CTL, 2'h0, 32'h0000_0ac8);
    repeat (40) @(posedge core_clk);
    wr(zlf_pkg::ZLF_REG_CTL, 2'h0, 32'h0000_0000);
    repeat (10) @(posedge core_clk);
    // second reset in mid-run
    track = 0;
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("reset pc", fetch_pc, 32'h0000_0000);
    check("reset ctl", {20'h0, loop_ctl}, 32'h0000_0000);
    @(posedge core_clk);
    reset <= 1'b0;
    restart();
    repeat (10) @(posedge core_clk);
    end_of_test();
  end
endmodule : testbench
